//--- pbwf_write_fwd.sv
// Purpose: delayed and posted write forwarding control of a PCI bridge
// Assumes: request strobes come from same-clock bus decode logic
// Notes:   Behaviour
// Behaviour
// - I/O writes and Type 1 config writes go as delayed writes.
// - a delayed write carries one DWORD, then disconnects.
// - first sight of a delayed write: claim, then target retry.
// - capture command, address, parities, data and byte enables.
// - new entry only without a tag match and with a free slot.
// - start delivery only at queue head with ordering satisfied.
// - on target retry keep reissuing until done or error.
// - after programmed attempt limit raise system error if enabled.
// - repeat matching completed head entry is claimed with TRDY.
// - repeat asking several DWORDs gets STOP with TRDY.
// - compare only data bytes whose byte enable is low.
// - repeat before delivery finishes gets target retry.
// - a repeat never allocates another entry.
// - discard timer starts at head completion, loaded from 78h.
// - unclaimed completion is dropped at expiry; error if enabled.
// - posted memory write stops at 4KB or cache line per 40h bit1.
// - MWI stops at 4KB for bad line size, else at line if short.
// - posted writes accepted while space remains; disconnect when full.
// - delayed writes accepted whenever a queue slot is free.
// - fast back-to-back posts; retry when buffer is too small.
`timescale 1ns/10ps
`default_nettype none
module pbwf_write_fwd
    import pbwf_pkg::*;
#(
    parameter int          DEPTH      = 4,
    parameter int          AW         = 2,
    parameter int          FREE_W     = 8,
    parameter logic [31:0] RETRY_INIT = RETRY_RST
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // delayed write request, first data phase
    input  wire logic              req_valid,
    input  wire logic [3:0]        req_cmd,
    input  wire logic [31:0]       req_addr,
    input  wire logic              req_apar,
    input  wire logic [31:0]       req_data,
    input  wire logic [3:0]        req_be_n,
    input  wire logic              req_dpar,
    input  wire logic              req_multi,
    // posted write data phase
    input  wire logic              pw_valid,
    input  wire logic              pw_first,
    input  wire logic              pw_last,
    input  wire logic [3:0]        pw_cmd,
    input  wire logic [31:0]       pw_addr,
    input  wire logic [FREE_W-1:0] posted_free,
    input  wire logic [7:0]        cache_line_size,
    // target answer on the initiator bus
    output logic                   tgt_devsel,
    output logic                   tgt_trdy,
    output logic                   tgt_stop,
    output logic                   pw_accept,
    // delivery on the target bus
    input  wire logic              ordering_ok,
    input  wire logic              out_done,
    input  wire logic              out_retry,
    input  wire logic              out_error,
    output logic                   out_start,
    output logic [3:0]             out_cmd,
    output logic [31:0]            out_addr,
    output logic                   out_apar,
    output logic [31:0]            out_data,
    output logic [3:0]             out_be_n,
    output logic                   out_dpar,
    // configuration access
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [31:0]       cfg_wdata,
    output logic [31:0]            cfg_rdata,
    input  wire logic              cmd_serr_en,
    // error
    output logic                   primary_system_error_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0]            vld;
        logic [DEPTH-1:0][TAG_W-1:0] tag;
        logic [AW-1:0]               head;
        logic [AW-1:0]               tail;
        logic [AW:0]                 cnt;
        logic                        head_done;
        logic                        wr_lag;
        pbwf_dly_e                   dst;
        logic [31:0]                 tries;
        logic [31:0]                 discard;
        logic [31:0]                 chip_ctrl;
        logic [31:0]                 retry_val;
        logic [31:0]                 cfg_rdata;
        logic                        devsel;
        logic                        trdy;
        logic                        stop;
        logic                        pw_accept;
        logic                        out_start;
        logic                        serr;
    } pbwf_state_s;

    localparam pbwf_state_s S_RST = '{
        dst: D_IDLE, chip_ctrl: CHIP_CTRL_RST, retry_val: RETRY_INIT,
        default: '0};

    pbwf_state_s      s;
    pbwf_state_s      next_s;
    logic [DEPTH-1:0] hit;
    logic             is_dly;
    logic             head_hit;
    logic             alloc;
    logic             pop;
    logic             pop_rep;
    logic             serr_ev;
    logic             pw_bound;
    pbwf_entry_s      hd;

    pbwf_dq_if #(.AW(AW)) dq ();

    pbwf_dq_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .sys_clk (sys_clk),
        .dq      (dq)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic data_eq(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [3:0]  be_n);
        data_eq = 1'b1;
        for (int k = 0; k < 4; k++) begin
            if (!be_n[k] && (a[8*k +: 8] != b[8*k +: 8])) begin
                data_eq = 1'b0;
            end
        end
    endfunction : data_eq

    function automatic logic line_end(input logic [31:0] a,
                                      input logic [7:0]  cls);
        line_end = (a[9:2] & (cls - 8'h01)) == (cls - 8'h01);
    endfunction : line_end

    function automatic logic cls_ok(input logic [7:0] cls);
        cls_ok = (cls == 8'h01) || (cls == 8'h02) || (cls == 8'h04) ||
                 (cls == 8'h08) || (cls == 8'h10);
    endfunction : cls_ok

    // ------------------------------------------------------------
    // tag match against every live entry
    // ------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : g_hit
        assign hit[g] = s.vld[g] && (s.tag[g] == {req_cmd, req_addr});
    end

    assign hd       = dq.rd_data;
    assign is_dly   = (req_cmd == CMD_IO_WR) ||
                      (req_cmd == CMD_CFG_WR &&
                       req_addr[1:0] == CFG_TYPE1);
    assign head_hit = hit[s.head] && s.head_done && !s.wr_lag &&
                      hd.be_n == req_be_n &&
                      data_eq(hd.data, req_data, req_be_n);

    // a line-end stop on MWI only when the buffer cannot take a full
    // next line; otherwise the burst runs on to 4KB
    always_comb begin
        if (pw_cmd == CMD_MWI) begin
            pw_bound = pw_addr[11:2] == KB_LAST_DW;
            if (cls_ok(cache_line_size) &&
                line_end(pw_addr, cache_line_size) &&
                posted_free <= FREE_W'(cache_line_size)) begin
                pw_bound = 1'b1;
            end
        end else if (s.chip_ctrl[WDC_BIT]) begin
            pw_bound = line_end(pw_addr, cache_line_size);
        end else begin
            pw_bound = pw_addr[11:2] == KB_LAST_DW;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.devsel    = 1'b0;
        next_s.trdy      = 1'b0;
        next_s.stop      = 1'b0;
        next_s.pw_accept = 1'b0;
        next_s.out_start = 1'b0;
        alloc            = 1'b0;
        pop_rep          = 1'b0;
        pop              = 1'b0;
        serr_ev          = 1'b0;

        // answers to the initiator
        if (req_valid && is_dly) begin
            next_s.devsel = 1'b1;
            if (head_hit) begin
                next_s.trdy = 1'b1;
                next_s.stop = req_multi;
                pop_rep     = 1'b1;
            end else begin
                next_s.stop = 1'b1;
                alloc = !(|hit) && (s.cnt < DEPTH);
            end
        end else if (pw_valid) begin
            next_s.devsel = 1'b1;
            if (pw_first && posted_free == '0) begin
                next_s.stop = 1'b1;
            end else begin
                next_s.trdy      = 1'b1;
                next_s.pw_accept = 1'b1;
                next_s.stop      = !pw_last &&
                    (posted_free == FREE_W'(1) || pw_bound);
            end
        end

        // delivery toward the target bus
        case (s.dst)
            D_IDLE: begin
                if (s.cnt != '0 && !s.head_done && !s.wr_lag &&
                    ordering_ok) begin
                    next_s.out_start = 1'b1;
                    next_s.dst       = D_WAIT;
                end
            end
            D_WAIT: begin
                if (out_done) begin
                    next_s.head_done = 1'b1;
                    next_s.discard   = s.retry_val;
                    next_s.dst       = D_IDLE;
                end else if (out_error) begin
                    pop        = 1'b1;
                    next_s.dst = D_IDLE;
                end else if (out_retry) begin
                    if (s.tries + 32'h1 == s.retry_val) begin
                        serr_ev    = 1'b1;
                        pop        = 1'b1;
                        next_s.dst = D_IDLE;
                    end else begin
                        next_s.tries = s.tries + 32'h1;
                        next_s.dst   = D_ISSUE;
                    end
                end
            end
            D_ISSUE: begin
                if (ordering_ok) begin
                    next_s.out_start = 1'b1;
                    next_s.dst       = D_WAIT;
                end
            end
            default: next_s.dst = D_IDLE;
        endcase

        // discard timer on a completed head entry
        if (s.head_done && !pop_rep) begin
            if (s.discard == '0) begin
                pop     = 1'b1;
                serr_ev = 1'b1;
            end else begin
                next_s.discard = s.discard - 32'h1;
            end
        end
        pop = pop || pop_rep;

        // queue bookkeeping
        if (alloc) begin
            next_s.vld[s.tail] = 1'b1;
            next_s.tag[s.tail] = {req_cmd, req_addr};
            next_s.tail        = s.tail + 1'b1;
        end
        if (pop) begin
            next_s.vld[s.head] = 1'b0;
            next_s.head        = s.head + 1'b1;
            next_s.head_done   = 1'b0;
            next_s.tries       = '0;
        end
        next_s.cnt    = s.cnt + {{AW{1'b0}}, alloc} - {{AW{1'b0}}, pop};
        next_s.wr_lag = alloc;
        next_s.serr   = serr_ev && cmd_serr_en;

        // configuration registers
        if (cfg_wr && cfg_addr == REG_CHIP_CTRL) begin
            next_s.chip_ctrl = cfg_wdata;
        end
        if (cfg_wr && cfg_addr == REG_RETRY) begin
            next_s.retry_val = cfg_wdata;
        end
        if (cfg_rd) begin
            case (cfg_addr)
                REG_CHIP_CTRL: next_s.cfg_rdata = s.chip_ctrl;
                REG_RETRY:     next_s.cfg_rdata = s.retry_val;
                default:       next_s.cfg_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= S_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // storage port and outputs
    // ------------------------------------------------------------
    assign dq.wr_en   = alloc;
    assign dq.wr_addr = s.tail;
    assign dq.wr_data = '{cmd: req_cmd, addr: req_addr, apar: req_apar,
                          data: req_data, be_n: req_be_n,
                          dpar: req_dpar};
    // read ahead so the registered head entry lines up with s.head
    assign dq.rd_addr = next_s.head;

    assign tgt_devsel = s.devsel;
    assign tgt_trdy   = s.trdy;
    assign tgt_stop   = s.stop;
    assign pw_accept  = s.pw_accept;
    assign out_start  = s.out_start;
    assign out_cmd    = hd.cmd;
    assign out_addr   = hd.addr;
    assign out_apar   = hd.apar;
    assign out_data   = hd.data;
    assign out_be_n   = hd.be_n;
    assign out_dpar   = hd.dpar;
    assign cfg_rdata  = s.cfg_rdata;
    assign primary_system_error_out = s.serr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_retry_on_miss: assert property (@(posedge sys_clk) disable iff (!reset_n)
        req_valid && is_dly && !head_hit |=> tgt_devsel && tgt_stop && !tgt_trdy)
        else $error("delayed write miss not retried");
    a_repeat_disc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        req_valid && is_dly && head_hit && req_multi |=> tgt_trdy && tgt_stop)
        else $error("multi dword repeat not disconnected");
    a_no_dup_alloc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        req_valid && (|hit) |-> !dq.wr_en)
        else $error("repeat allocated an entry");
    a_full_no_alloc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s.cnt >= DEPTH |=> s.cnt <= DEPTH)
        else $error("queue overfilled");
    a_issue_order: assert property (@(posedge sys_clk) disable iff (!reset_n)
        out_start |-> $past(ordering_ok) && s.dst == D_WAIT)
        else $error("delivery started without ordering");
    a_retry_reissue: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s.dst == D_WAIT && out_retry && !out_done && !out_error && !serr_ev
        ##1 ordering_ok |=> out_start)
        else $error("retried write not reissued");
    a_serr_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        primary_system_error_out |-> $past(cmd_serr_en))
        else $error("system error without enable");
    a_discard_drop: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s.head_done && s.discard == '0 && !pop_rep |=> !s.head_done)
        else $error("expired completion kept");
    a_fb2b_retry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !req_valid && pw_valid && pw_first && posted_free == '0
        |=> tgt_stop && !tgt_trdy && !pw_accept)
        else $error("posted write with no space not retried");
    a_buf_disc: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !req_valid && pw_valid && !pw_first && !pw_last &&
        posted_free == FREE_W'(1) |=> tgt_trdy && tgt_stop)
        else $error("last buffer dword not disconnected");

endmodule : pbwf_write_fwd
`default_nettype wire

//--- pbwf_pkg.sv
// Purpose: shared constants and types for the write-forwarding block
// Assumes: PCI clock is sys_clk; one DWORD per delayed entry
// Notes:   config offsets are byte addresses in configuration space
package pbwf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CHIP_CTRL = 8'h40;
    localparam logic [7:0]  REG_RETRY     = 8'h78;
    localparam logic [31:0] CHIP_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] RETRY_RST     = 32'h0100_0000;
    localparam int          WDC_BIT       = 1;

    // ------------------------------------------------------------
    // bus commands and address fields
    // ------------------------------------------------------------
    localparam logic [3:0]  CMD_IO_WR     = 4'h3;
    localparam logic [3:0]  CMD_MEM_WR    = 4'h7;
    localparam logic [3:0]  CMD_CFG_WR    = 4'hB;
    localparam logic [3:0]  CMD_MWI       = 4'hF;
    localparam logic [1:0]  CFG_TYPE1     = 2'h1;
    localparam logic [9:0]  KB_LAST_DW    = 10'h3FF;
    localparam int          TAG_W         = 36;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        D_IDLE  = 2'b00,
        D_WAIT  = 2'b01,
        D_ISSUE = 2'b11
    } pbwf_dly_e;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic        apar;
        logic [31:0] data;
        logic [3:0]  be_n;
        logic        dpar;
    } pbwf_entry_s;

endpackage : pbwf_pkg

//--- pbwf_dq_if.sv
// Purpose: port bundle between controller and delayed-queue storage
// Assumes: single clock, registered read
// Notes:   read address is presented one cycle before data is used
`timescale 1ns/10ps
`default_nettype none
interface pbwf_dq_if
    import pbwf_pkg::*;
#(
    parameter int AW = 2
);
    logic              wr_en;
    logic [AW-1:0]     wr_addr;
    pbwf_entry_s       wr_data;
    logic [AW-1:0]     rd_addr;
    pbwf_entry_s       rd_data;

    modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : pbwf_dq_if
`default_nettype wire

//--- pbwf_dq_mem.sv
// Purpose: storage for delayed write entries
// Assumes: DEPTH equals 2**AW
// Notes:   read data comes from a register, no reset on the array
`timescale 1ns/10ps
`default_nettype none
module pbwf_dq_mem
    import pbwf_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock
    input  wire logic  sys_clk,
    // storage port
    pbwf_dq_if.mem     dq
);
    pbwf_entry_s mem [DEPTH];

    // ------------------------------------------------------------
    // write and registered read
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (dq.wr_en) begin
            mem[dq.wr_addr] <= dq.wr_data;
        end
        dq.rd_data <= mem[dq.rd_addr];
    end
endmodule : pbwf_dq_mem
`default_nettype wire

//--- pbwf_tgt_model.sv
// Purpose: target on the far bus answering delayed write attempts
// Assumes: one attempt outstanding, result four cycles after start
// Notes:   retry_n sets how many retries precede each completion
`timescale 1ns/10ps
`default_nettype none
module pbwf_tgt_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // attempt and behaviour
    input  wire logic       out_start,
    input  wire logic [7:0] retry_n,
    // result pulses
    output logic            out_done,
    output logic            out_retry,
    output logic            out_error
);
    logic [1:0] cnt;
    logic [7:0] tries;

    // ------------------------------------------------------------
    // one result pulse per attempt
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt       <= 2'h0;
            tries     <= 8'h00;
            out_done  <= 1'b0;
            out_retry <= 1'b0;
            out_error <= 1'b0;
        end else begin
            out_done  <= 1'b0;
            out_retry <= 1'b0;
            out_error <= 1'b0;
            if (out_start) begin
                cnt <= 2'h3;
            end else if (cnt == 2'h1) begin
                cnt <= 2'h0;
                // 8'hFF never completes within the attempt limit
                if (tries < retry_n) begin
                    out_retry <= 1'b1;
                    tries     <= tries + 8'h01;
                end else begin
                    out_done <= 1'b1;
                    tries    <= 8'h00;
                end
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
            end
        end
    end
endmodule : pbwf_tgt_model
`default_nettype wire

//--- pbwf_write_fwd_tb.sv
// Purpose: self-checking bench for the write-forwarding block
// Assumes: attempt limit and discard time shortened to 8
// Notes:   expectations come from the documented behaviour only
`timescale 1ns/10ps
`default_nettype none
module pbwf_write_fwd_tb;
    import pbwf_pkg::*;
    localparam logic [31:0] LIM = 32'h0000_0008;
    logic sys_clk = 1'b0, reset_n = 1'b0, req_valid, req_apar, req_dpar;
    logic req_multi, pw_valid, pw_first, pw_last, ordering_ok, out_done;
    logic out_retry, out_error, cfg_wr, cfg_rd, cmd_serr_en, tgt_devsel;
    logic tgt_trdy, tgt_stop, pw_accept, out_start, out_apar, out_dpar;
    logic primary_system_error_out;
    logic [3:0]  req_cmd, req_be_n, pw_cmd, out_cmd, out_be_n;
    logic [31:0] req_addr, req_data, pw_addr, out_addr, out_data;
    logic [31:0] cfg_wdata, cfg_rdata, rd;
    logic [7:0]  posted_free, cache_line_size, cfg_addr, retry_n;
    logic [2:0]  a;
    int          err_count, cmp_count, serr_n, starts, s0, e0;

    pbwf_write_fwd #(.RETRY_INIT(LIM)) u_pbwf_write_fwd (
        .sys_clk, .reset_n, .req_valid, .req_cmd, .req_addr, .req_apar,
        .req_data, .req_be_n, .req_dpar, .req_multi, .pw_valid, .pw_first,
        .pw_last, .pw_cmd, .pw_addr, .posted_free, .cache_line_size,
        .tgt_devsel, .tgt_trdy, .tgt_stop, .pw_accept, .ordering_ok,
        .out_done, .out_retry, .out_error, .out_start, .out_cmd, .out_addr,
        .out_apar, .out_data, .out_be_n, .out_dpar, .cfg_wr, .cfg_rd,
        .cfg_addr, .cfg_wdata, .cfg_rdata, .cmd_serr_en,
        .primary_system_error_out);
    pbwf_tgt_model u_pbwf_tgt_model (.sys_clk, .reset_n, .out_start,
        .retry_n, .out_done, .out_retry, .out_error);

    // ------------------------------------------------------------
    // clock, event counters, tasks
    // ------------------------------------------------------------
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (primary_system_error_out === 1'b1) serr_n++;
        if (out_start === 1'b1) starts++;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic dreq(input logic [3:0] c, input logic [31:0] ad, d,
                        input logic [3:0] be, input logic m);
        req_valid = 1'b1; req_cmd = c; req_addr = ad; req_data = d;
        req_be_n = be; req_multi = m; req_apar = ^ad; req_dpar = ^d;
        cyc(1);
        a = {tgt_devsel, tgt_trdy, tgt_stop};
        req_valid = 1'b0;
        cyc(1);
    endtask : dreq
    task automatic cfg(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        cfg_wr = w; cfg_rd = !w; cfg_addr = ad; cfg_wdata = d;
        cyc(1);
        rd = cfg_rdata;
        cfg_wr = 1'b0; cfg_rd = 1'b0;
        cyc(1);
    endtask : cfg
    task automatic pchk(input logic f, l, input logic [3:0] c,
                        input logic [31:0] ad, input logic [7:0] fr,
                        input logic [3:0] exp);
        pw_valid = 1'b1; pw_first = f; pw_last = l; pw_cmd = c;
        pw_addr = ad; posted_free = fr;
        cyc(1);
        chk({tgt_devsel, tgt_trdy, tgt_stop, pw_accept}, exp);
        pw_valid = 1'b0;
        cyc(1);
    endtask : pchk
    task automatic wait_done(input logic [31:0] ad, d);
        for (int i = 0; i < 100 && out_done !== 1'b1; i++) cyc(1);
        chk(out_done, 1);
        chk({out_cmd, out_be_n}, {CMD_IO_WR, 4'h8});
        chk(out_addr, ad);
        chk(out_data, d);
        chk({out_apar, out_dpar}, {^ad, ^d});
        // head entry is marked delivered one edge after the done pulse
        cyc(1);
    endtask : wait_done
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {req_valid, req_apar, req_dpar, req_multi, pw_valid} = '0;
        {pw_first, pw_last, cfg_wr, cfg_rd, req_cmd, req_be_n} = '0;
        {req_addr, req_data, pw_cmd, pw_addr, cfg_addr, cfg_wdata} = '0;
        {posted_free, retry_n} = '0;
        cache_line_size = 8'h04; ordering_ok = 1'b1; cmd_serr_en = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        cyc(1);
        cfg(0, REG_CHIP_CTRL, 0); chk(rd, CHIP_CTRL_RST);
        cfg(0, REG_RETRY, 0); chk(rd, LIM);
        cfg(0, 8'h10, 0); chk(rd, 0);
        $display("registers done");
        // slow target: one retry, then completion
        retry_n = 8'h01; e0 = serr_n;
        dreq(CMD_IO_WR, 32'h0000_2000, 32'h1122_3344, 4'h8, 0);
        chk(a, 3'b101);
        dreq(CMD_IO_WR, 32'h0000_2000, 32'h1122_3344, 4'h8, 0);
        chk(a, 3'b101);
        wait_done(32'h0000_2000, 32'h1122_3344);
        // top byte disabled, so its differing value must not matter
        dreq(CMD_IO_WR, 32'h0000_2000, 32'hFF22_3344, 4'h8, 1);
        chk(a, 3'b111);
        chk(starts - s0, 2);
        chk(serr_n - e0, 0);
        $display("delayed completion done");
        // queue fill with ordering held off, then expiry of each
        retry_n = 8'h00; ordering_ok = 1'b0;
        dreq(4'h6, 32'h0000_3000, 0, 4'h0, 0); chk(a, 3'b000);
        s0 = starts; e0 = serr_n;
        for (int i = 0; i < 5; i++) begin
            dreq(CMD_CFG_WR, 32'h0001_0001 + 32'(i) * 4, i, 4'h0, 0);
            chk(a, 3'b101);
        end
        cyc(5); chk(starts - s0, 0);
        ordering_ok = 1'b1;
        cyc(150);
        chk(starts - s0, 4);
        chk(serr_n - e0, 4);
        $display("discard done");
        // target never completes: attempt limit reached
        retry_n = 8'hFF; s0 = starts; e0 = serr_n;
        dreq(CMD_IO_WR, 32'h0000_4000, 32'hA5A5_A5A5, 4'h0, 0);
        cyc(150);
        chk(starts - s0, LIM); chk(serr_n - e0, 1);
        $display("retry limit done");
        // posted disconnects: 4KB, buffer space, cache line
        pchk(1, 0, CMD_MEM_WR, 32'h0000_0FFC, 8'h05, 4'hF);
        pchk(1, 0, CMD_MEM_WR, 32'h0000_0100, 8'h05, 4'hD);
        pchk(0, 0, CMD_MEM_WR, 32'h0000_0104, 8'h01, 4'hF);
        pchk(1, 1, CMD_MEM_WR, 32'h0000_0200, 8'h00, 4'hA);
        cfg(1, REG_CHIP_CTRL, 32'h0000_0002);
        pchk(1, 0, CMD_MEM_WR, 32'h0000_010C, 8'h05, 4'hF);
        pchk(1, 0, CMD_MWI, 32'h0000_010C, 8'h04, 4'hF);
        pchk(1, 0, CMD_MWI, 32'h0000_010C, 8'h05, 4'hD);
        cache_line_size = 8'h03;
        pchk(1, 0, CMD_MWI, 32'h0000_010C, 8'h02, 4'hD);
        pchk(1, 0, CMD_MWI, 32'h0000_1FFC, 8'h05, 4'hF);
        $display("posted done");
        finish_test();
    end

    // a hang ends the run through the same closing task
    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule : pbwf_write_fwd_tb
`default_nettype wire
